// ---- adc_cfg.svh ----
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADC_ADDR_CONFIG      5'h08
`define ADC_ADDR_STATUS      5'h09

// ****************************************************************
// Configuration field positions and reset values
// ****************************************************************
`define ADC_CFG_CLK_SEL_BIT  0
`define ADC_CFG_TEMP_BIT     3
`define ADC_CFG_RATE_LO_BIT  4
`define ADC_CFG_RATE_HI_BIT  5
`define ADC_CFG_SOFT_RST_BIT 6
`define ADC_CFG_BAND_BIT     7
`define ADC_CFG_RESET        8'h00
`define ADC_STATUS_RESET     8'h01

// ****************************************************************
// Timing
// ****************************************************************
`define ADC_CLK_PERIOD_NS    8
`define ADC_RESET_TIME_NS    1000
`define ADC_RESET_CYCLES     \
    ((`ADC_RESET_TIME_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_SAMPLE_PERIOD_NS 125000
`define ADC_SAMPLE_CYCLES    (`ADC_SAMPLE_PERIOD_NS / `ADC_CLK_PERIOD_NS)

`endif

// ---- adc_config_status_regs.sv ----
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_config_status_regs #(
    parameter int SAMPLE_CYCLES = `ADC_SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Converter controls
    output logic             temperature_select,
    output logic      [1:0]  output_rate_select,
    output logic             filter_bandwidth_select,
    output logic             reset_in_progress,
    output logic             sample_tick,
    // Shared clock-out or sample-ready pin
    output logic             ready_or_clock_pin
);

    // ****************************************************************
    // State
    // ****************************************************************
    // Power-on and software reset share this value, so both give the
    // same defaults and the same length of reset.
    localparam adc_pkg::adc_main_state_type RESET_STATE = '{
        clk_sel:  1'b0,
        temp_sel: 1'b0,
        rate:     adc_pkg::ADC_RATE_8K,
        soft_rst: 1'b0,
        band_sel: 1'b0,
        phase:    adc_pkg::ADC_PH_RESET,
        cnt:      10'(`ADC_RESET_CYCLES - 1),
        rdata:    8'h00,
        pin:      1'b0
    };

    adc_pkg::adc_main_state_type s;
    adc_pkg::adc_main_state_type next_s;
    logic                        busy;
    logic                        cfg_wr;

    adc_rate_if rif ();

    adc_rate_gen #(
        .BASE_CYCLES (SAMPLE_CYCLES)
    ) adc_rate_gen_inst (
        .clk  (clk),
        .srst (srst),
        .rif  (rif)
    );

    assign busy   = (s.phase == adc_pkg::ADC_PH_RESET);
    // Writes during reset are dropped so a half-reset block is not
    // reconfigured; the host polls the status bit first.
    assign cfg_wr = reg_wr && (reg_addr == `ADC_ADDR_CONFIG) && !busy
                    && !s.soft_rst;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.pin = s.clk_sel ? rif.clk_toggle : rif.sample_tick;
        if (s.soft_rst) begin
            next_s = RESET_STATE;
            next_s.pin = s.pin;
        end else if (busy) begin
            if (s.cnt == 10'h0) begin
                next_s.phase = adc_pkg::ADC_PH_RUN;
            end else begin
                next_s.cnt = s.cnt - 10'h1;
            end
        end else if (cfg_wr) begin
            // Bits 1 and 2 are not stored at all.
            next_s.clk_sel  = reg_wdata[`ADC_CFG_CLK_SEL_BIT];
            next_s.temp_sel = reg_wdata[`ADC_CFG_TEMP_BIT];
            next_s.rate     = adc_pkg::adc_rate_type'(
                reg_wdata[`ADC_CFG_RATE_HI_BIT:`ADC_CFG_RATE_LO_BIT]);
            next_s.soft_rst = reg_wdata[`ADC_CFG_SOFT_RST_BIT];
            next_s.band_sel = reg_wdata[`ADC_CFG_BAND_BIT];
        end
        if (reg_rd) begin
            case (reg_addr)
                `ADC_ADDR_CONFIG: begin
                    next_s.rdata = {s.band_sel, s.soft_rst, s.rate, s.temp_sel,
                                    2'b00, s.clk_sel};
                end
                `ADC_ADDR_STATUS: begin
                    next_s.rdata = {7'h00, busy};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rif.run                 = !busy;
    assign rif.rate_sel            = s.rate;
    assign reg_rdata               = s.rdata;
    assign temperature_select      = s.temp_sel;
    assign output_rate_select      = s.rate;
    assign filter_bandwidth_select = s.band_sel;
    assign reset_in_progress       = busy;
    assign sample_tick             = rif.sample_tick;
    assign ready_or_clock_pin      = s.pin;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence trig_write_s;
        cfg_wr && reg_wdata[`ADC_CFG_SOFT_RST_BIT];
    endsequence

    sequence self_clear_s;
        s.soft_rst ##1 !s.soft_rst;
    endsequence

    soft_clear_a: assert property (
        trig_write_s |=> self_clear_s)
        else $error("Reset trigger did not clear after one cycle.");

    soft_starts_a: assert property (
        trig_write_s |-> ##2 reset_in_progress)
        else $error("Reset trigger did not start a reset.");

    reset_defaults_a: assert property (
        s.soft_rst |=> (!s.clk_sel && !s.temp_sel && !s.band_sel
                     && s.rate == adc_pkg::ADC_RATE_8K))
        else $error("Software reset left a field off its default.");

    busy_hold_a: assert property (
        s.soft_rst |=> reset_in_progress [*8])
        else $error("Reset flag dropped early.");

    busy_end_a: assert property (
        busy && s.cnt == 10'h0 |=> !reset_in_progress && $past(busy))
        else $error("Reset flag did not clear at the end of reset.");

    status_read_a: assert property (
        reg_rd && reg_addr == `ADC_ADDR_STATUS
        |=> reg_rdata == {7'h00, $past(busy)})
        else $error("Status read does not show reset state.");

    // The pin is frozen for the one cycle in which a trigger reloads
    // the defaults, so that cycle is left out of this check.
    pin_mux_a: assert property (
        !$past(s.soft_rst) |-> ready_or_clock_pin == ($past(s.clk_sel)
            ? $past(rif.clk_toggle) : $past(rif.sample_tick)))
        else $error("Shared pin shows the wrong function.");

    temp_route_a: assert property (
        cfg_wr |=> temperature_select == $past(reg_wdata[3]))
        else $error("Temperature select not taken from bit 3.");

    rate_write_a: assert property (
        cfg_wr |=> output_rate_select == $past(reg_wdata[5:4]))
        else $error("Rate select not taken from bits 5 to 4.");

    band_write_a: assert property (
        cfg_wr |=> filter_bandwidth_select == $past(reg_wdata[7]))
        else $error("Bandwidth select not taken from bit 7.");

    reserved_read_a: assert property (
        reg_rd && reg_addr == `ADC_ADDR_CONFIG |=> reg_rdata[2:1] == 2'b00)
        else $error("Unused configuration bits did not read zero.");

    // The count runs down once per cycle, so the flag cannot drop
    // before the full reset span has elapsed.
    cnt_bound_a: assert property (
        busy |-> s.cnt <= 10'(`ADC_RESET_CYCLES - 1))
        else $error("Reset counter above its start value.");

    busy_count_a: assert property (
        busy && s.cnt != 10'h0 |=> busy && s.cnt == $past(s.cnt) - 10'h1)
        else $error("Reset counter did not step down by one.");

    soft_reload_a: assert property (
        s.soft_rst |=> reset_in_progress
                       && s.cnt == 10'(`ADC_RESET_CYCLES - 1))
        else $error("Software reset did not restart the reset count.");

    busy_defaults_a: assert property (
        busy |-> !s.clk_sel && !temperature_select && !filter_bandwidth_select
                 && output_rate_select == 2'b00)
        else $error("A field left its default during reset.");

    write_refused_a: assert property (
        busy |=> $stable(temperature_select) && $stable(output_rate_select)
                 && $stable(filter_bandwidth_select) && $stable(s.clk_sel))
        else $error("A write changed the configuration during reset.");

    tick_quiet_a: assert property (
        busy && $past(busy) |-> !sample_tick)
        else $error("Sample tick during reset.");

endmodule // adc_config_status_regs

// ---- adc_config_status_regs_bench.sv ----
`timescale 1ns/1ps
`include "adc_cfg.svh"
`define CHK(nm, e, a) \
    begin \
        comparisons++; \
        if ((a) !== (e)) begin \
            err_total++; \
            $display("unexpected %s exp %h got %h", nm, e, a); \
        end \
    end
module adc_config_status_regs_bench;
    localparam int SC = 8;
    logic       clk;
    logic       srst;
    logic       reg_wr;
    logic       reg_rd;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] q;
    logic       temperature_select;
    logic [1:0] output_rate_select;
    logic       filter_bandwidth_select;
    logic       reset_in_progress;
    logic       sample_tick;
    logic       ready_or_clock_pin;
    int         err_total;
    int         comparisons;
    int         n;

    adc_config_status_regs #(.SAMPLE_CYCLES(SC)) adc_config_status_regs_inst (
        .clk                     (clk),
        .srst                    (srst),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_rdata               (reg_rdata),
        .temperature_select      (temperature_select),
        .output_rate_select      (output_rate_select),
        .filter_bandwidth_select (filter_bandwidth_select),
        .reset_in_progress       (reset_in_progress),
        .sample_tick             (sample_tick),
        .ready_or_clock_pin      (ready_or_clock_pin)
    );

    adc_host_model adc_host_model_inst (
        .clk       (clk),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************
    // Helpers
    // ************************************************
    // Both waits are bounded so a dead design ends in a mismatch.
    task automatic wait_tick();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sample_tick !== 1'b1 && n < 300);
    endtask

    task automatic wait_idle();
        n = 0;
        while (reset_in_progress !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (comparisons > 0 && err_total == 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        err_total   = 0;
        comparisons = 0;
        srst        = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        adc_host_model_inst.rd(`ADC_ADDR_STATUS, q);
        `CHK("status busy", 8'h01, q);
        wait_idle();
        `CHK("reset span", 1'b1, n >= 118 && n <= 126);
        adc_host_model_inst.rd(`ADC_ADDR_CONFIG, q);
        `CHK("config default", 8'h00, q);
        adc_host_model_inst.rd(`ADC_ADDR_STATUS, q);
        `CHK("status idle", 8'h00, q);
        adc_host_model_inst.wr(`ADC_ADDR_CONFIG, 8'hbf);
        adc_host_model_inst.rd(`ADC_ADDR_CONFIG, q);
        `CHK("config spare bits", 8'hb9, q);
        `CHK("temperature", 1'b1, temperature_select);
        `CHK("bandwidth", 1'b1, filter_bandwidth_select);
        for (int r = 0; r < 4; r++) begin
            adc_host_model_inst.wr(`ADC_ADDR_CONFIG, {2'b00, r[1:0], 4'h0});
            wait_tick();
            wait_tick();
            `CHK("tick spacing", SC << r, n);
            `CHK("rate", r[1:0], output_rate_select);
            `CHK("temperature off", 1'b0, temperature_select);
            @(negedge clk);
            `CHK("ready pulse", 1'b1, ready_or_clock_pin);
        end
        adc_host_model_inst.wr(`ADC_ADDR_CONFIG, 8'hb9);
        @(negedge clk);
        q[0] = ready_or_clock_pin;
        @(negedge clk);
        `CHK("clock pin", ~q[0], ready_or_clock_pin);
        adc_host_model_inst.wr(`ADC_ADDR_CONFIG, 8'hf9);
        adc_host_model_inst.rd(`ADC_ADDR_CONFIG, q);
        `CHK("soft reset bit", 8'hf9, q);
        adc_host_model_inst.rd(`ADC_ADDR_CONFIG, q);
        `CHK("after soft reset", 8'h00, q);
        `CHK("soft busy", 1'b1, reset_in_progress);
        `CHK("rate default", 2'b00, output_rate_select);
        `CHK("band default", 1'b0, filter_bandwidth_select);
        `CHK("temperature default", 1'b0, temperature_select);
        `CHK("pin quiet", 1'b0, ready_or_clock_pin);
        adc_host_model_inst.rd(`ADC_ADDR_STATUS, q);
        `CHK("soft status", 8'h01, q);
        adc_host_model_inst.wr(`ADC_ADDR_CONFIG, 8'h38);
        wait_idle();
        `CHK("soft done", 1'b0, reset_in_progress);
        adc_host_model_inst.rd(`ADC_ADDR_CONFIG, q);
        `CHK("write in reset", 8'h00, q);
        finish_test();
    end
endmodule // adc_config_status_regs_bench

// ---- adc_host_model.sv ----
`timescale 1ns/1ps
// ************************************************
// Host side of the register port
// ************************************************
module adc_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [4:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 5'h00;
        reg_wdata = 8'h00;
    end

    // Callers start at a falling edge and never issue two writes back
    // to back. The data is scrambled after the strobe, as a real host
    // gives no guarantee that it holds.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        @(negedge clk);
        q        = reg_rdata;
    endtask
endmodule // adc_host_model

// ---- adc_pkg.sv ----
package adc_pkg;

    typedef enum logic [1:0] {
        ADC_RATE_8K = 2'b00,
        ADC_RATE_4K = 2'b01,
        ADC_RATE_2K = 2'b10,
        ADC_RATE_1K = 2'b11
    } adc_rate_type;

    typedef enum logic {
        ADC_PH_RUN   = 1'b0,
        ADC_PH_RESET = 1'b1
    } adc_phase_type;

    typedef struct packed {
        logic          clk_sel;
        logic          temp_sel;
        adc_rate_type  rate;
        logic          soft_rst;
        logic          band_sel;
        adc_phase_type phase;
        logic [9:0]    cnt;
        logic [7:0]    rdata;
        logic          pin;
    } adc_main_state_type;

    typedef struct packed {
        logic [19:0] cnt;
        logic        tick;
        logic        clk_toggle;
    } adc_rate_state_type;

endpackage

// ---- adc_rate_gen.sv ----
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_rate_gen #(
    parameter int BASE_CYCLES = `ADC_SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control side
    adc_rate_if.gen  rif
);

    adc_pkg::adc_rate_state_type s;
    adc_pkg::adc_rate_state_type next_s;
    logic [19:0]                 limit;

    // The period doubles for each step of the rate field.
    assign limit = (20'(BASE_CYCLES) << rif.rate_sel) - 20'h1;

    always_comb begin
        next_s = s;
        next_s.clk_toggle = ~s.clk_toggle;
        next_s.tick = 1'b0;
        if (!rif.run) begin
            next_s.cnt = 20'h0;
        end else if (s.cnt >= limit) begin
            next_s.cnt = 20'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 20'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rif.sample_tick = s.tick;
    assign rif.clk_toggle  = s.clk_toggle;

endmodule // adc_rate_gen

// ---- adc_rate_if.sv ----
`timescale 1ns/1ps
interface adc_rate_if;
    logic                  run;
    adc_pkg::adc_rate_type rate_sel;
    logic                  sample_tick;
    logic                  clk_toggle;

    modport ctl (output run, output rate_sel,
                 input sample_tick, input clk_toggle);
    modport gen (input run, input rate_sel,
                 output sample_tick, output clk_toggle);
endinterface
